/* verilog/dqpc_pkg.sv */
package dqpc_pkg;

   // Width of each ring count and of each set-point.
   localparam int CountWidth = 24;
   // Highest count before the ring wraps to zero.
   localparam logic [23:0] CountMax = 24'hFF_FFFF;

   // Register byte offsets; channel two sits ChanStride above channel one.
   localparam logic [7:0] OffsCount   = 8'h00;
   localparam logic [7:0] OffsSetOne  = 8'h04;
   localparam logic [7:0] OffsSetTwo  = 8'h08;
   localparam logic [7:0] OffsMode    = 8'h0C;
   localparam logic [7:0] ChanStride  = 8'h10;
   localparam logic [7:0] OffsIrqStat = 8'h20;
   localparam logic [7:0] OffsIrqMask = 8'h24;

   // Mode register field positions.
   localparam int ModeLsb      = 0;
   localparam int ModeMsb      = 2;
   localparam int SwapBit      = 4;
   localparam int PrecisionBit = 5;

   // Reset values.
   localparam logic [23:0] CountReset = 24'h00_0000;
   localparam logic [23:0] SetReset   = 24'h00_0000;

   // Interrupt status bits per channel: wrap, above rise, below rise.
   localparam int IrqPerChan = 3;

   // Internal timer tick period in cycles (1 kHz at 20 MHz by default).
   localparam int ClockHz = 20_000_000;
   localparam int TickHz  = 1_000;
   localparam int TickCycles = ClockHz / TickHz;

   // Seven operating modes; universal and speed only count phase A edges up.
   typedef enum logic [2:0] {
      ModeQuad,
      ModeUpDown,
      ModeAutoReset,
      ModeUniversal,
      ModeSpeed,
      ModeIntervalTimer,
      ModeGateTimer
   } dqpc_mode_t;

endpackage : dqpc_pkg

/* verilog/dqpc_top.sv */
// Contract
// - Two channels, each counts to 100 kpps
// - Seven modes, chosen per channel
// - Modes one-five external, six-seven timer
// - A leading counts up, B leading down
// - Ring count wraps max to zero
// - Decrement at zero wraps to max
// - Two host set-points compared per channel
// - Above output when count exceeds first
// - Below output when count under second
// - Each channel drives its own pair
// - Host reads and writes count, set-points
// - Per-channel phase swap, default unswapped
// - Precision counts both edges, normal one
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dqpc_top #(
   parameter int TickCycles = dqpc_pkg::TickCycles
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  phaseA,
   input  wire logic [1:0]  phaseB,
   input  wire logic [1:0]  gateIn,
   output logic      [1:0]  aboveCompareOutput,
   output logic      [1:0]  belowCompareOutput,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.
   ////////////////////////////////////////////////////////////////////////

   // One-cycle access: the slave answers in the first access cycle.
   // No wait states are ever inserted, so transfers take two cycles.
   assign pready = 1'b1;

   // A write or read is taken in the access phase.
   logic busWrite;
   logic busRead;
   assign busWrite = psel & penable & pwrite;
   assign busRead  = psel & penable & ~pwrite;

   // Unmapped offsets raise an error in the access phase.
   // Mapped words are the ten aligned offsets below the first gap.
   logic mapped;
   assign mapped = (paddr < 8'h28) && (paddr[1:0] == 2'b00);
   assign pslverr = psel & penable & ~mapped;

   // Shared timer tick for the timer modes.
   // The divider is 32 bits wide so any sensible tick period fits.
   logic [31:0] tickCnt_q;
   logic        tick;
   assign tick = (tickCnt_q == 32'(TickCycles - 1));

   // Free-running tick divider.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tickCnt_q <= 32'h0000_0000;
      end else if (tick) begin
         tickCnt_q <= 32'h0000_0000;
      end else begin
         tickCnt_q <= tickCnt_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel counters.
   ////////////////////////////////////////////////////////////////////////

   // Status bits contributed by each channel.
   localparam int IrqPerChanW = dqpc_pkg::IrqPerChan;

   // Per-channel state visible to the register read mux.
   // Held count of each channel.
   logic [23:0] count    [2];
   // First set-point of each channel.
   logic [23:0] setOne   [2];
   // Second set-point of each channel.
   logic [23:0] setTwo   [2];
   // Six-bit mode field of each channel.
   logic [5:0]  modeReg  [2];
   // Event pulses of each channel.
   logic [IrqPerChanW-1:0] chanEvt [2];

   for (genvar ch = 0; ch < 2; ch++) begin : gChan
      // Channel register base offset; channel two sits one stride up.
      // The product is kept to the address width on purpose.
      localparam logic [7:0] Base = 8'(ch) * dqpc_pkg::ChanStride;

      // Held count, set-points and mode.
      logic [23:0] count_q;
      logic [23:0] count_d;
      logic [23:0] setOne_q;
      logic [23:0] setTwo_q;
      logic [5:0]  mode_q;
      // Previous input levels for edge detection.
      logic        a_q;
      logic        b_q;
      logic        g_q;
      // Comparison outputs from flip-flops.
      logic        above_q;
      logic        below_q;
      // Step request and wrap flag.
      logic        up;
      logic        down;
      logic        wrap;
      // Phases after the optional swap.
      logic        a;
      logic        b;
      // Edge pulses of the swapped phases.
      logic        aRise;
      logic        aFall;
      logic        bRise;
      logic        bFall;
      // Precision setting and preset strobe.
      logic        precise;
      logic        presetWr;
      // Decoded operating mode.
      dqpc_pkg::dqpc_mode_t mode;

      assign mode    = dqpc_pkg::dqpc_mode_t'(
                          mode_q[dqpc_pkg::ModeMsb:dqpc_pkg::ModeLsb]);
      assign precise = mode_q[dqpc_pkg::PrecisionBit];
      assign a = mode_q[dqpc_pkg::SwapBit] ? phaseB[ch] : phaseA[ch];
      assign b = mode_q[dqpc_pkg::SwapBit] ? phaseA[ch] : phaseB[ch];
      assign aRise = a & ~a_q;
      assign aFall = ~a & a_q;
      assign bRise = b & ~b_q;
      assign bFall = ~b & b_q;
      assign presetWr = busWrite && (paddr == Base + dqpc_pkg::OffsCount);

      // Step decode per mode; quadrature decodes direction from phases.
      always_comb begin
         up   = 1'b0;
         down = 1'b0;
         case (mode)
            dqpc_pkg::ModeQuad: begin
               if (aRise) begin
                  up   = ~b;
                  down = b & precise;
               end else if (aFall & precise) begin
                  up   = b;
                  down = ~b;
               end else if (bRise & precise) begin
                  up   = a;
                  down = ~a;
               end else if (bFall & precise) begin
                  up   = ~a;
                  down = a;
               end else if (aFall) begin
                  // Normal setting: phase A falling with B low counts down.
                  down = ~b;
               end
            end
            dqpc_pkg::ModeUpDown: begin
               up   = aRise | (precise & aFall);
               down = bRise | (precise & bFall);
            end
            dqpc_pkg::ModeAutoReset,
            dqpc_pkg::ModeUniversal,
            dqpc_pkg::ModeSpeed: begin
               up = aRise | (precise & aFall);
            end
            // Timer modes count the shared tick instead of the phases.
            dqpc_pkg::ModeIntervalTimer: begin
               up = tick;
            end
            dqpc_pkg::ModeGateTimer: begin
               up = tick & gateIn[ch];
            end
            default: begin
               up = 1'b0;
            end
         endcase
      end

      // Next count: preset wins, then wrapping step.
      always_comb begin
         count_d = count_q;
         wrap    = 1'b0;
         if (presetWr) begin
            count_d = pwdata[23:0];
         end else if (up & ~down) begin
            wrap    = (count_q == dqpc_pkg::CountMax);
            count_d = count_q + 24'h00_0001;
            // Auto-reset folds the count to zero on reaching set-point one.
            if (mode == dqpc_pkg::ModeAutoReset &&
                count_q + 24'h00_0001 == setOne_q) begin
               count_d = dqpc_pkg::CountReset;
            end
         end else if (down & ~up) begin
            wrap    = (count_q == 24'h00_0000);
            count_d = count_q - 24'h00_0001;
         end else if (mode == dqpc_pkg::ModeGateTimer &&
                      gateIn[ch] & ~g_q) begin
            // A rising gate restarts the timer count in a cycle with no preset and no tick.
            count_d = dqpc_pkg::CountReset;
         end
      end

      // Count, edge history and comparison outputs.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            count_q <= dqpc_pkg::CountReset;
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            g_q     <= 1'b0;
            above_q <= 1'b0;
            below_q <= 1'b0;
         end else begin
            count_q <= count_d;
            a_q     <= a;
            b_q     <= b;
            g_q     <= gateIn[ch];
            above_q <= (count_d > setOne_q);
            below_q <= (count_d < setTwo_q);
         end
      end

      // Host-written set-points and mode.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            setOne_q <= dqpc_pkg::SetReset;
            setTwo_q <= dqpc_pkg::SetReset;
            mode_q   <= 6'h00;
         end else if (busWrite) begin
            // host access
            // Writes outside this channel's window leave it unchanged.
            if (paddr == Base + dqpc_pkg::OffsSetOne) begin
               setOne_q <= pwdata[23:0];
            end
            if (paddr == Base + dqpc_pkg::OffsSetTwo) begin
               setTwo_q <= pwdata[23:0];
            end
            if (paddr == Base + dqpc_pkg::OffsMode) begin
               mode_q <= pwdata[5:0];
            end
         end
      end

      // Drive this channel's own comparison pair and the mux views.
      assign aboveCompareOutput[ch] = above_q;
      assign belowCompareOutput[ch] = below_q;
      assign count[ch]   = count_q;
      assign setOne[ch]  = setOne_q;
      assign setTwo[ch]  = setTwo_q;
      assign modeReg[ch] = mode_q;
      // Events: below rising, above rising and wrap, from the next count.
      assign chanEvt[ch] = {(count_d < setTwo_q) & ~below_q,
                            (count_d > setOne_q) & ~above_q,
                            wrap};
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts.
   ////////////////////////////////////////////////////////////////////////

   // Sticky status, cleared by a read; a new event wins over the clear.
   logic [5:0] irqStat_q;
   logic [5:0] irqMask_q;
   logic [5:0] events;
   logic       statRead;
   // Channel one owns the low three bits, channel two the high three.
   assign events   = {chanEvt[1], chanEvt[0]};
   // A status read in the access phase clears what it returns and any bit set at the setup edge.
   assign statRead = busRead && (paddr == dqpc_pkg::OffsIrqStat);

   // Status register update.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqStat_q <= 6'h00;
      end else if (statRead) begin
         irqStat_q <= events;
      end else begin
         irqStat_q <= irqStat_q | events;
      end
   end

   // Mask register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqMask_q <= 6'h00;
      end else if (busWrite && paddr == dqpc_pkg::OffsIrqMask) begin
         irqMask_q <= pwdata[5:0];
      end
   end

   // Level interrupt, high while any unmasked status bit is set.
   assign irq = |(irqStat_q & irqMask_q);

   ////////////////////////////////////////////////////////////////////////
   // Read data.
   ////////////////////////////////////////////////////////////////////////

   // Read mux, registered at the setup cycle so data is valid in access.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            dqpc_pkg::OffsCount:   prdata <= {8'h00, count[0]};
            dqpc_pkg::OffsSetOne:  prdata <= {8'h00, setOne[0]};
            dqpc_pkg::OffsSetTwo:  prdata <= {8'h00, setTwo[0]};
            dqpc_pkg::OffsMode:    prdata <= {26'h0, modeReg[0]};
            // Channel two sits one stride above channel one.
            dqpc_pkg::ChanStride + dqpc_pkg::OffsCount:
               prdata <= {8'h00, count[1]};
            dqpc_pkg::ChanStride + dqpc_pkg::OffsSetOne:
               prdata <= {8'h00, setOne[1]};
            dqpc_pkg::ChanStride + dqpc_pkg::OffsSetTwo:
               prdata <= {8'h00, setTwo[1]};
            dqpc_pkg::ChanStride + dqpc_pkg::OffsMode:
               prdata <= {26'h0, modeReg[1]};
            dqpc_pkg::OffsIrqStat: prdata <= {26'h0, irqStat_q};
            dqpc_pkg::OffsIrqMask: prdata <= {26'h0, irqMask_q};
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : dqpc_top

`default_nettype wire

/* dv/dqpc_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Watches bus answers and compare outputs at the top-level pins.
module dqpc_top_checker #(
   parameter int TickCycles = 4
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  phaseA,
   input wire logic [1:0]  phaseB,
   input wire logic [1:0]  gateIn,
   input wire logic [1:0]  aboveCompareOutput,
   input wire logic [1:0]  belowCompareOutput,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Write or read completing at this edge.
   logic wr;
   logic rd;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   ready_high_a: assert property (pready)
      else $error("pready low");
   bad_addr_a: assert property (psel && penable && paddr >= 8'h28 |-> pslverr)
      else $error("no error on unmapped access");
   bad_read_a: assert property (rd && paddr >= 8'h28 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (rd |-> prdata[31:24] == 8'h0)
      else $error("upper read bits set");
   top_above_a: assert property (wr && paddr == 8'h04 &&
      pwdata[23:0] == 24'hFF_FFFF |=> ##1 !aboveCompareOutput[0])
      else $error("above set against max");
   zero_below_a: assert property (wr && paddr == 8'h08 &&
      pwdata[23:0] == 24'h0 |=> ##1 !belowCompareOutput[0])
      else $error("below set against zero");
   preset_low_a: assert property (wr && paddr == 8'h10 &&
      pwdata[23:0] == 24'h0 |=> !aboveCompareOutput[1])
      else $error("preset zero left above set");
   preset_top_a: assert property (wr && paddr == 8'h00 &&
      pwdata[23:0] == 24'hFF_FFFF |=> !belowCompareOutput[0])
      else $error("preset max left below set");
   reset_idle_a: assert property ($fell(rst) |->
      !irq && aboveCompareOutput == 2'b00 && belowCompareOutput == 2'b00)
      else $error("outputs not idle after reset");
   mask_off_a: assert property (wr && paddr == 8'h24 &&
      pwdata[5:0] == 6'h0 |=> ##1 !irq)
      else $error("irq high with mask clear");
   cover property (wr && paddr == 8'h00);
   cover property (irq);
   cover property (rd && pslverr);
endmodule : dqpc_top_checker
bind dqpc_top dqpc_top_checker #(.TickCycles(TickCycles)) chk (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB),
   .gateIn(gateIn), .aboveCompareOutput(aboveCompareOutput),
   .belowCompareOutput(belowCompareOutput), .irq(irq));
`default_nettype wire

/* dv/dqpc_qenc.sv */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Encoder model: two quadrature sources, one per channel.
module dqpc_qenc #(
   parameter int Quarter = 100
) (
   input wire logic  clock,
   output logic [1:0] phaseA,
   output logic [1:0] phaseB
);
   // Gray position of each channel.
   logic [1:0] pos [2];
   initial begin
      phaseA = 2'b00;
      phaseB = 2'b00;
      pos[0] = 2'b00;
      pos[1] = 2'b00;
   end
   // Turns n whole cycles forward (A leads) or backward.
   task automatic spin(input int ch, input bit fwd, input int n);
      for (int i = 0; i < 4 * n; i++) begin
         pos[ch] = fwd ? pos[ch] + 2'd1 : pos[ch] - 2'd1;
         phaseA[ch] <= pos[ch][0] ^ pos[ch][1];
         phaseB[ch] <= pos[ch][1];
         repeat (Quarter) @(posedge clock);
      end
   endtask : spin
endmodule : dqpc_qenc
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the two-channel counter.
module tb;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdv;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        irq;
   logic [1:0]  phaseA;
   logic [1:0]  phaseB;
   logic [1:0]  above;
   logic [1:0]  below;
   logic [1:0]  gateIn = 2'b00;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cyc = 0;
   always #25 clock = ~clock;
   dqpc_top #(.TickCycles(4)) dut (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phaseA(phaseA),
      .phaseB(phaseB), .gateIn(gateIn), .aboveCompareOutput(above),
      .belowCompareOutput(below), .irq(irq));
   dqpc_qenc enc (.clock(clock), .phaseA(phaseA), .phaseB(phaseB));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   // One bus transfer, then one idle cycle.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Waits for pready; only the bench timeout ends a hung wait.
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask : rd
   task automatic s_ring();
      apb(1'b1, 8'h24, 32'h1);
      apb(1'b1, 8'h00, 32'h00FF_FFFF);
      enc.spin(0, 1'b1, 1);
      rd(8'h00, 32'h0);
      chk(irq, 32'h1);
      rd(8'h20, 32'h3);
      repeat (2) @(posedge clock);
      chk(irq, 32'h0);
      enc.spin(0, 1'b0, 1);
      rd(8'h00, 32'h00FF_FFFF);
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h0C, 32'h20);
      enc.spin(0, 1'b1, 1);
      rd(8'h00, 32'h3);
      apb(1'b1, 8'h0C, 32'h10);
      enc.spin(0, 1'b1, 1);
      rd(8'h00, 32'h2);
   endtask : s_ring
   task automatic s_cmp();
      apb(1'b1, 8'h04, 32'h00FF_FFFF);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h14, 32'hA);
      apb(1'b1, 8'h18, 32'hA);
      apb(1'b1, 8'h10, 32'hA);
      chk({above, below}, 32'h0);
      enc.spin(1, 1'b1, 1);
      chk({above, below}, 32'h8);
      enc.spin(1, 1'b0, 2);
      chk({above, below}, 32'h2);
      apb(1'b1, 8'h10, 32'h14);
      chk({above, below}, 32'h8);
      rd(8'h14, 32'hA);
   endtask : s_cmp
   task automatic s_modes();
      logic [31:0] v0;
      for (int m = 0; m < 7; m++) begin
         apb(1'b1, 8'h1C, m);
         rd(8'h1C, m);
      end
      apb(1'b1, 8'h14, 32'hFFFF);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h1C, 32'h5);
      apb(1'b0, 8'h10, 32'h0);
      v0 = rdv;
      // Setup edges 40 cycles apart span exactly ten ticks of four.
      repeat (37) @(posedge clock);
      apb(1'b0, 8'h10, 32'h0);
      chk(rdv - v0, 32'hA);
      apb(1'b1, 8'h1C, 32'h0);
      apb(1'b1, 8'h28, 32'h5);
      chk(err, 32'h1);
      rd(8'h28, 32'h0);
      apb(1'b1, 8'h24, 32'h3F);
      rd(8'h24, 32'h3F);
   endtask : s_modes
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // Cuts a hang short.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 10000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(8'h00, 32'h0);
      rd(8'h0C, 32'h0);
      chk({above, below, irq}, 32'h0);
      s_ring();
      s_cmp();
      s_modes();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
